// ===== aes128_ecb_cipher_core_test.sv
// self-checking bench joining the cipher core and its user end
`timescale 1ns/1ps
module aes128_ecb_cipher_core_test import aesc_pkg::*;;
   localparam aesc_blk_t KEY_A = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
   localparam aesc_blk_t PT_A  = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
   localparam aesc_blk_t CT_A  = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
   localparam aesc_blk_t KEY_B = 128'h2b7e_1516_28ae_d2a6_abf7_1588_09cf_4f3c;
   localparam aesc_blk_t PT_B  = 128'h3243_f6a8_885a_308d_3131_98a2_e037_0734;
   localparam aesc_blk_t CT_B  = 128'h3925_841d_02dc_09fb_dc11_8597_196a_0b32;
   logic      ref_clk_in = 1'b0;
   logic      sys_rst_in = 1'b1;
   aesc_blk_t key_in = '0;
   logic      key_load_in = 1'b0;
   logic      key_load_ready_out;
   logic      key_valid_out;
   aesc_blk_t blk_data_in = '0;
   logic      blk_encrypt_in = 1'b0;
   logic      blk_valid_in = 1'b0;
   logic      blk_ready_out;
   logic      abort_in = 1'b0;
   aesc_blk_t res_data_out;
   logic      res_valid_out;
   logic      res_ready_in = 1'b0;
   logic      core_ready_out;
   int        mismatches = 0;
   int        total_checks = 0;
   int        n;
   bit        ok;
   always #5 ref_clk_in = ~ref_clk_in;
   aesc_if aesc_if_inst ();
   aesc_core_end aesc_core_end_inst (
      .ref_clk_in (ref_clk_in), .sys_rst_in (sys_rst_in), .link (aesc_if_inst.dev));
   aesc_user_end #(.BLOCK_CYCLES(44)) aesc_user_end_inst (
      .ref_clk_in (ref_clk_in), .sys_rst_in (sys_rst_in), .key_in (key_in),
      .key_load_in (key_load_in), .key_load_ready_out (key_load_ready_out),
      .key_valid_out (key_valid_out), .blk_data_in (blk_data_in),
      .blk_encrypt_in (blk_encrypt_in), .blk_valid_in (blk_valid_in),
      .blk_ready_out (blk_ready_out), .abort_in (abort_in), .res_data_out (res_data_out),
      .res_valid_out (res_valid_out), .res_ready_in (res_ready_in),
      .core_ready_out (core_ready_out), .link (aesc_if_inst.usr));
   aesc_link_assertions #(.INIT_CYCLES(1024), .BLOCK_CYCLES(44)) aesc_link_assertions_inst (
      .ref_clk_in (ref_clk_in), .sys_rst_in (sys_rst_in), .enable (aesc_if_inst.enable),
      .sync_clear (aesc_if_inst.sync_clear), .encrypt_select (aesc_if_inst.encrypt_select),
      .data (aesc_if_inst.data), .key_word_in (aesc_if_inst.key_word_in),
      .key_word_select (aesc_if_inst.key_word_select),
      .key_word_write (aesc_if_inst.key_word_write),
      .key_expand_strobe (aesc_if_inst.key_expand_strobe),
      .result_out (aesc_if_inst.result_out), .result_valid (aesc_if_inst.result_valid),
      .ready (aesc_if_inst.ready), .key_expanded_flag (aesc_if_inst.key_expanded_flag));
   task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // outputs are sampled at the falling edge, inputs move at the rising edge
   task automatic load_key(input aesc_blk_t k);
      int i;
      for (i = 0; i < 200 && key_load_ready_out !== 1'b1; i++) @(negedge ref_clk_in);
      check("key_load_ready_out", 128'(key_load_ready_out), 128'h1);
      @(posedge ref_clk_in);
      key_in <= k;
      key_load_in <= 1'b1;
      @(posedge ref_clk_in);
      key_load_in <= 1'b0;
      repeat (8) @(negedge ref_clk_in);
      check("key_valid_out low", 128'(key_valid_out), 128'h0);
      check("key_load_ready_out busy", 128'(key_load_ready_out), 128'h0);
      for (i = 0; i < 100 && key_valid_out !== 1'b1; i++) @(negedge ref_clk_in);
      check("key_valid_out high", 128'(key_valid_out), 128'h1);
   endtask
   task automatic send_block(input aesc_blk_t d, input logic enc, output bit taken);
      int i;
      @(posedge ref_clk_in);
      blk_data_in <= d;
      blk_encrypt_in <= enc;
      blk_valid_in <= 1'b1;
      @(negedge ref_clk_in);
      for (i = 0; i < 150 && blk_ready_out !== 1'b1; i++) @(negedge ref_clk_in);
      taken = (blk_ready_out === 1'b1);
      @(posedge ref_clk_in);
      blk_valid_in <= 1'b0;
   endtask
   task automatic get_result(input string name, input aesc_blk_t exp);
      int i;
      for (i = 0; i < 200 && res_valid_out !== 1'b1; i++) @(negedge ref_clk_in);
      check("res_valid_out", 128'(res_valid_out), 128'h1);
      check(name, res_data_out, exp);
      @(posedge ref_clk_in);
      res_ready_in <= 1'b1;
      @(posedge ref_clk_in);
      res_ready_in <= 1'b0;
   endtask
   initial begin
      repeat (15000) @(posedge ref_clk_in);
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      repeat (1000) @(negedge ref_clk_in);
      check("core_ready_out early", 128'(core_ready_out), 128'h0);
      check("key_valid_out reset", 128'(key_valid_out), 128'h0);
      for (n = 0; n < 60 && core_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
      check("core_ready_out", 128'(core_ready_out), 128'h1);
      load_key(KEY_A);
      send_block(PT_A, 1'b1, ok);
      get_result("encrypt a", CT_A);
      send_block(CT_A, 1'b0, ok);
      get_result("decrypt a", PT_A);
      load_key(KEY_B);
      send_block(CT_B, 1'b0, ok);
      get_result("decrypt b", PT_B);
      // receiver stalls: two slots fill, third block pauses at its end, all must survive
      n = 0;
      ok = 1'b1;
      while (ok && n < 4) begin
         send_block(PT_B, 1'b1, ok);
         if (ok) n++;
      end
      check("blocks held", 128'(n), 128'h3);
      repeat (n) get_result("buffered b", CT_B);
      @(negedge ref_clk_in);
      check("buffer empty", 128'(res_valid_out), 128'h0);
      send_block(PT_A, 1'b1, ok);
      repeat (10) @(posedge ref_clk_in);
      abort_in <= 1'b1;
      @(posedge ref_clk_in);
      abort_in <= 1'b0;
      repeat (80) @(negedge ref_clk_in);
      check("aborted result", 128'(res_valid_out), 128'h0);
      check("key kept", 128'(key_valid_out), 128'h1);
      send_block(PT_B, 1'b1, ok);
      get_result("after abort", CT_B);
      // reset again mid-run: key flag and ready must fall back
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(negedge ref_clk_in);
      check("key_valid_out reset again", 128'(key_valid_out), 128'h0);
      check("core_ready_out reset again", 128'(core_ready_out), 128'h0);
      end_of_test();
   end
endmodule // aes128_ecb_cipher_core_test

// ===== aesc_core_end.sv
// block cipher core: 128-bit key, codebook mode, 44 cycles per block
`timescale 1ns/1ps
`include "aesc_defs.svh"
module aesc_core_end
   import aesc_pkg::*;
#(
   parameter int INIT_CYCLES  = `AESC_INIT_CYCLES,
   parameter int BLOCK_CYCLES = `AESC_BLOCK_CYCLES,
   parameter int KEY_EXPAND_STROBE_CYCLES  = `AESC_KEY_EXPAND_STROBE_CYCLES
) (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic sys_rst_in,
   // link to user logic
   aesc_if.dev       link
);

   aesc_dev_state_t q_reg;
   aesc_dev_state_t q_next;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? `AESC_GF_POLY : 8'h00);
   endfunction

   function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ x;
         end
         x = xt(x);
      end
      return p;
   endfunction

   // inverse as x^254; no table, trades area for a tiny source
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] p;
      r = 8'h01;
      p = a;
      for (int i = 0; i < 7; i++) begin
         p = gm(p, p);
         r = gm(r, p);
      end
      return r;
   endfunction

   function automatic logic [7:0] rl(input logic [7:0] b, input int n);
      return 8'((b << n) | (b >> (8 - n)));
   endfunction

   function automatic logic [7:0] sb(input logic [7:0] b, input logic inv);
      logic [7:0] t;
      if (inv) begin
         t = rl(b, 1) ^ rl(b, 3) ^ rl(b, 6) ^ `AESC_ISBOX_AFFINE;
         return ginv(t);
      end
      t = ginv(b);
      return t ^ rl(t, 1) ^ rl(t, 2) ^ rl(t, 3) ^ rl(t, 4) ^ `AESC_SBOX_AFFINE;
   endfunction

   function automatic aesc_blk_t sub_bytes(input aesc_blk_t s, input logic inv);
      aesc_blk_t o;
      o = s;
      for (int i = 0; i < 16; i++) begin
         o[127-8*i -: 8] = sb(s[127-8*i -: 8], inv);
      end
      return o;
   endfunction

   function automatic aesc_blk_t shift_rows(input aesc_blk_t s, input logic inv);
      aesc_blk_t o;
      int        src;
      o = s;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            src = inv ? ((c - r + 4) % 4) : ((c + r) % 4);
            o[127-8*(r+4*c) -: 8] = s[127-8*(r+4*src) -: 8];
         end
      end
      return o;
   endfunction

   function automatic aesc_blk_t mix_cols(input aesc_blk_t s, input logic inv);
      aesc_blk_t  o;
      logic [7:0] m [4];
      o = s;
      m[0] = inv ? 8'h0e : 8'h02;
      m[1] = inv ? 8'h0b : 8'h03;
      m[2] = inv ? 8'h0d : 8'h01;
      m[3] = inv ? 8'h09 : 8'h01;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            o[127-8*(r+4*c) -: 8] = gm(s[127-8*(((r+0)%4)+4*c) -: 8], m[0])
                                  ^ gm(s[127-8*(((r+1)%4)+4*c) -: 8], m[1])
                                  ^ gm(s[127-8*(((r+2)%4)+4*c) -: 8], m[2])
                                  ^ gm(s[127-8*(((r+3)%4)+4*c) -: 8], m[3]);
         end
      end
      return o;
   endfunction

   function automatic aesc_blk_t enc_round(input aesc_blk_t s, input aesc_blk_t k,
                                           input logic last);
      aesc_blk_t t;
      t = shift_rows(sub_bytes(s, 1'b0), 1'b0);
      return (last ? t : mix_cols(t, 1'b0)) ^ k;
   endfunction

   function automatic aesc_blk_t dec_round(input aesc_blk_t s, input aesc_blk_t k,
                                           input logic last);
      aesc_blk_t t;
      t = sub_bytes(shift_rows(s, 1'b1), 1'b1) ^ k;
      return last ? t : mix_cols(t, 1'b1);
   endfunction

   function automatic logic [7:0] rcon(input logic [3:0] k);
      logic [7:0] r;
      r = `AESC_RCON_FIRST;
      for (int i = 2; i <= `AESC_ROUNDS; i++) begin
         if (i <= int'(k)) begin
            r = xt(r);
         end
      end
      return r;
   endfunction

   function automatic aesc_blk_t key_step(input aesc_blk_t w, input logic [3:0] k);
      aesc_word_t t;
      aesc_word_t n0;
      aesc_word_t n1;
      aesc_word_t n2;
      t = {sb(w[23:16], 1'b0), sb(w[15:8], 1'b0), sb(w[7:0], 1'b0), sb(w[31:24], 1'b0)};
      t = t ^ {rcon(k), 24'h00_0000};
      n0 = w[127:96] ^ t;
      n1 = w[95:64] ^ n0;
      n2 = w[63:32] ^ n1;
      return {n0, n1, n2, w[31:0] ^ n2};
   endfunction

   logic       go;
   logic [3:0] rnd;

   always_comb begin
      q_next = q_reg;
      q_next.res_val = 1'b0;
      rnd = q_reg.cnt[5:2];
      // the data path does not advance before init is done or while paused
      go = link.enable & q_reg.ready;
      if (!q_reg.ready) begin
         if (q_reg.init_cnt == 11'(INIT_CYCLES - 1)) begin
            q_next.ready = 1'b1;
         end else begin
            q_next.init_cnt = q_reg.init_cnt + 11'd1;
         end
      end
      // key path sees only reset, write and strobe; clear is not consulted
      if (link.key_word_write) begin
         q_next.key[link.key_word_select] = link.key_word_in;
         q_next.kflag = 1'b0;
         q_next.kbusy = 1'b0;
      end else if (link.key_expand_strobe) begin
         q_next.rk[0] = {q_reg.key[3], q_reg.key[2], q_reg.key[1], q_reg.key[0]};
         q_next.kcnt = 6'd1;
         q_next.kbusy = 1'b1;
         q_next.kflag = 1'b0;
      end else if (q_reg.kbusy) begin
         if (q_reg.kcnt <= 6'(`AESC_ROUNDS)) begin
            q_next.rk[q_reg.kcnt[3:0]] = key_step(q_reg.rk[q_reg.kcnt[3:0] - 4'd1],
                                                  q_reg.kcnt[3:0]);
         end
         if (q_reg.kcnt == 6'(KEY_EXPAND_STROBE_CYCLES)) begin
            q_next.kflag = 1'b1;
            q_next.kbusy = 1'b0;
         end else begin
            q_next.kcnt = q_reg.kcnt + 6'd1;
         end
      end
      // data path
      if (link.sync_clear) begin
         q_next.cnt = 6'd0;
         q_next.st = '0;
      end else if (go) begin
         if (q_reg.cnt == 6'd0) begin
            // fresh block each time, no state carried over
            q_next.dec = ~link.encrypt_select;
            q_next.st = link.data ^ (link.encrypt_select ? q_reg.rk[0]
                                                       : q_reg.rk[`AESC_ROUNDS]);
         end else if (q_reg.cnt[1:0] == 2'd0 &&
                      q_reg.cnt <= 6'(`AESC_ROUNDS * `AESC_ROUND_STEP)) begin
            q_next.st = q_reg.dec
               ? dec_round(q_reg.st, q_reg.rk[4'(`AESC_ROUNDS) - rnd],
                           rnd == 4'(`AESC_ROUNDS))
               : enc_round(q_reg.st, q_reg.rk[rnd], rnd == 4'(`AESC_ROUNDS));
         end
         if (q_reg.cnt == 6'(BLOCK_CYCLES - 1)) begin
            q_next.res = q_reg.st;
            q_next.res_val = 1'b1;
            q_next.cnt = 6'd0;
         end else begin
            q_next.cnt = q_reg.cnt + 6'd1;
         end
      end
      // when go and clear are low, cnt, st and dec keep their value; res_val still drops
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign link.result_out        = q_reg.res;
   assign link.result_valid      = q_reg.res_val;
   assign link.ready             = q_reg.ready;
   assign link.key_expanded_flag = q_reg.kflag;

endmodule // aesc_core_end

// ===== aesc_defs.svh
// timing counts, sizes and constants of the block cipher core
`ifndef AESC_DEFS_SVH
`define AESC_DEFS_SVH
`define AESC_INIT_CYCLES   1024
`define AESC_BLOCK_CYCLES  44
`define AESC_KEY_EXPAND_STROBE_CYCLES   52
`define AESC_ROUNDS        10
`define AESC_ROUND_STEP    4
`define AESC_KEY_WORDS     4
`define AESC_FIFO_DEPTH    2
`define AESC_GF_POLY       8'h1b
`define AESC_SBOX_AFFINE   8'h63
`define AESC_ISBOX_AFFINE  8'h05
`define AESC_RCON_FIRST    8'h01
`endif

// ===== aesc_end_marker.sv
// intentionally empty compile unit
`timescale 1ns/1ps

// ===== aesc_if.sv
// link between the cipher core and the user logic that drives it
`timescale 1ns/1ps
interface aesc_if;
   logic         enable;
   logic         sync_clear;
   logic         encrypt_select;
   logic [127:0] data;
   logic [31:0]  key_word_in;
   logic [1:0]   key_word_select;
   logic         key_word_write;
   logic         key_expand_strobe;
   logic [127:0] result_out;
   logic         result_valid;
   logic         ready;
   logic         key_expanded_flag;

   modport dev (
      input  enable, sync_clear, encrypt_select, data,
      input  key_word_in, key_word_select, key_word_write, key_expand_strobe,
      output result_out, result_valid, ready, key_expanded_flag
   );
   modport usr (
      output enable, sync_clear, encrypt_select, data,
      output key_word_in, key_word_select, key_word_write, key_expand_strobe,
      input  result_out, result_valid, ready, key_expanded_flag
   );
endinterface // aesc_if

// ===== aesc_link_assertions.sv
// concurrent checks on the link between the cipher core and its user end
`timescale 1ns/1ps
module aesc_link_assertions #(
   parameter int INIT_CYCLES  = 1024,
   parameter int BLOCK_CYCLES = 44
) (
   // clock and reset
   input wire logic         ref_clk_in,
   input wire logic         sys_rst_in,
   // user to core
   input wire logic         enable,
   input wire logic         sync_clear,
   input wire logic         encrypt_select,
   input wire logic [127:0] data,
   input wire logic [31:0]  key_word_in,
   input wire logic [1:0]   key_word_select,
   input wire logic         key_word_write,
   input wire logic         key_expand_strobe,
   // core to user
   input wire logic [127:0] result_out,
   input wire logic         result_valid,
   input wire logic         ready,
   input wire logic         key_expanded_flag
);
   // flag is sampled one edge after the 52nd edge past the strobe
   localparam int KEY_EXPAND_STROBE_LAG = 53;
   logic [10:0] init_cnt_reg;
   logic [5:0]  blk_cnt_reg;
   logic        fire;
   // count of enabled edges; only a full run of them yields a result
   assign fire = enable && ready && !sync_clear && (blk_cnt_reg == 6'(BLOCK_CYCLES - 1));
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         init_cnt_reg <= '0;
         blk_cnt_reg  <= '0;
      end else begin
         if (init_cnt_reg < 11'(INIT_CYCLES)) begin
            init_cnt_reg <= init_cnt_reg + 11'h1;
         end
         if (sync_clear) begin
            blk_cnt_reg <= '0;
         end else if (enable && ready) begin
            blk_cnt_reg <= fire ? 6'h0 : blk_cnt_reg + 6'h1;
         end
      end
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   chk_ready_init: assert property (ready == (init_cnt_reg >= 11'(INIT_CYCLES)))
      else $error("ready not tied to end of init");
   chk_valid_pulse: assert property (result_valid |=> !result_valid)
      else $error("result_valid longer than one cycle");
   chk_valid_due: assert property (fire |=> result_valid)
      else $error("result_valid missing after full block");
   chk_valid_cause: assert property (result_valid |-> $past(fire))
      else $error("result_valid without full block");
   chk_flag_drop: assert property (key_word_write |=> !key_expanded_flag)
      else $error("key flag not dropped on key write");
   chk_flag_wait: assert property (key_expand_strobe |=> !key_expanded_flag)
      else $error("key flag high right after strobe");
   chk_flag_rise: assert property ($rose(key_expanded_flag) |->
      $past(key_expand_strobe && !key_word_write, KEY_EXPAND_STROBE_LAG))
      else $error("key flag rise not timed from strobe");
   chk_clear_keeps: assert property (sync_clear && key_expanded_flag && !key_word_write
      && !key_expand_strobe |=> key_expanded_flag)
      else $error("clear disturbed key flag");
   chk_sel_steady: assert property (enable && ready && blk_cnt_reg != 6'h0
      |-> $stable(encrypt_select))
      else $error("encrypt_select moved inside a block");
   chk_load_paused: assert property (key_word_write || key_expand_strobe |-> !enable)
      else $error("key load while core enabled");
endmodule // aesc_link_assertions

// ===== aesc_pkg.sv
// types shared by both ends of the block cipher link
package aesc_pkg;
   typedef logic [127:0] aesc_blk_t;
   typedef logic [31:0]  aesc_word_t;

   typedef struct packed {
      logic [3:0][31:0]   key;
      logic [10:0][127:0] rk;
      logic               kbusy;
      logic [5:0]         kcnt;
      logic               kflag;
      logic [10:0]        init_cnt;
      logic               ready;
      logic [5:0]         cnt;
      logic               dec;
      aesc_blk_t          st;
      aesc_blk_t          res;
      logic               res_val;
   } aesc_dev_state_t;

   typedef enum logic [2:0] {
      AESC_H_INIT,
      AESC_H_IDLE,
      AESC_H_KWR,
      AESC_H_KEY_EXPAND_STROBE,
      AESC_H_KWAIT,
      AESC_H_RUN
   } aesc_host_st_t;

   typedef struct packed {
      aesc_host_st_t      st;
      logic [5:0]         hcnt;
      logic               pend;
      logic               clr;
      logic [1:0]         kidx;
      aesc_blk_t          key;
      aesc_blk_t          data;
      logic               enc;
      logic [1:0][127:0]  mem;
      logic               wr;
      logic               rd;
      logic [1:0]         fcnt;
   } aesc_host_state_t;
endpackage

// ===== aesc_user_end.sv
// user logic end: key loading, block issue and two-entry result buffer
`timescale 1ns/1ps
`include "aesc_defs.svh"
module aesc_user_end
   import aesc_pkg::*;
#(
   parameter int BLOCK_CYCLES = `AESC_BLOCK_CYCLES
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         sys_rst_in,
   // key load
   input  wire logic [127:0] key_in,
   input  wire logic         key_load_in,
   output logic              key_load_ready_out,
   output logic              key_valid_out,
   // block request
   input  wire logic [127:0] blk_data_in,
   input  wire logic         blk_encrypt_in,
   input  wire logic         blk_valid_in,
   output logic              blk_ready_out,
   input  wire logic         abort_in,
   // results
   output logic [127:0]      res_data_out,
   output logic              res_valid_out,
   input  wire logic         res_ready_in,
   output logic              core_ready_out,
   // link to core
   aesc_if.usr               link
);

   aesc_host_state_t q_reg;
   aesc_host_state_t q_next;
   logic             start_ok;
   logic             chain_ok;
   logic             push;
   logic             pop;
   logic             hold;

   always_comb begin
      q_next = q_reg;
      q_next.clr = abort_in;
      // full buffer pauses the block at its last step, so the one-cycle result is never lost
      hold = q_reg.st == AESC_H_RUN && q_reg.hcnt == 6'(BLOCK_CYCLES - 1)
           && q_reg.fcnt == 2'(`AESC_FIFO_DEPTH);
      // one block in flight; it may start on a full buffer and wait there
      start_ok = q_reg.st == AESC_H_IDLE && !key_load_in && !abort_in && !q_reg.clr
               && link.key_expanded_flag && (q_reg.fcnt + {1'b0, q_reg.pend}) < 2'd3;
      chain_ok = q_reg.st == AESC_H_RUN && !abort_in
               && q_reg.hcnt == 6'(BLOCK_CYCLES - 1) && q_reg.fcnt == 2'd0;
      push = link.result_valid && q_reg.fcnt != 2'(`AESC_FIFO_DEPTH);
      pop = res_ready_in && q_reg.fcnt != 2'd0;
      if (push) begin
         q_next.mem[q_reg.wr] = link.result_out;
         q_next.wr = ~q_reg.wr;
         q_next.pend = 1'b0;
      end
      if (pop) begin
         q_next.rd = ~q_reg.rd;
      end
      q_next.fcnt = q_reg.fcnt + {1'b0, push} - {1'b0, pop};
      unique case (q_reg.st)
         AESC_H_INIT: begin
            if (link.ready) begin
               q_next.st = AESC_H_IDLE;
            end
         end
         AESC_H_IDLE: begin
            if (key_load_in && !abort_in) begin
               q_next.key = key_in;
               q_next.kidx = 2'd0;
               q_next.st = AESC_H_KWR;
            end else if (start_ok && blk_valid_in) begin
               q_next.data = blk_data_in;
               q_next.enc = blk_encrypt_in;
               q_next.hcnt = 6'd0;
               q_next.st = AESC_H_RUN;
            end
         end
         AESC_H_KWR: begin
            if (q_reg.kidx == 2'(`AESC_KEY_WORDS - 1)) begin
               q_next.st = AESC_H_KEY_EXPAND_STROBE;
            end else begin
               q_next.kidx = q_reg.kidx + 2'd1;
            end
         end
         AESC_H_KEY_EXPAND_STROBE: begin
            q_next.st = AESC_H_KWAIT;
         end
         AESC_H_KWAIT: begin
            if (link.key_expanded_flag) begin
               q_next.st = AESC_H_IDLE;
            end
         end
         AESC_H_RUN: begin
            if (abort_in) begin
               q_next.st = AESC_H_IDLE;
               q_next.pend = 1'b0;
            end else if (hold) begin
               q_next.hcnt = q_reg.hcnt;
            end else if (q_reg.hcnt == 6'(BLOCK_CYCLES - 1)) begin
               // unless the next block chains, enable drops on the edge that raises valid, so no stray edge starts a block
               q_next.pend = 1'b1;
               if (chain_ok && blk_valid_in) begin
                  q_next.data = blk_data_in;
                  q_next.enc = blk_encrypt_in;
                  q_next.hcnt = 6'd0;
               end else begin
                  q_next.st = AESC_H_IDLE;
               end
            end else begin
               q_next.hcnt = q_reg.hcnt + 6'd1;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign link.enable            = q_reg.st == AESC_H_RUN && !hold;
   assign link.sync_clear        = q_reg.clr;
   assign link.encrypt_select    = q_reg.enc;
   assign link.data              = q_reg.data;
   assign link.key_word_select   = q_reg.kidx;
   assign link.key_word_in       = q_reg.key[32*q_reg.kidx +: 32];
   assign link.key_word_write    = q_reg.st == AESC_H_KWR;
   assign link.key_expand_strobe = q_reg.st == AESC_H_KEY_EXPAND_STROBE;

   assign key_load_ready_out = q_reg.st == AESC_H_IDLE && !abort_in;
   assign key_valid_out      = link.key_expanded_flag;
   assign blk_ready_out      = (start_ok || chain_ok) && blk_valid_in;
   assign res_data_out       = q_reg.mem[q_reg.rd];
   assign res_valid_out      = q_reg.fcnt != 2'd0;
   assign core_ready_out     = link.ready;

endmodule // aesc_user_end
